// *** hw/uart_cfg_pkg.sv ***
package uart_cfg_pkg;
  // register word addresses
  localparam logic [2:0] ADDR_MODE = 3'h0;
  localparam logic [2:0] ADDR_STATUS = 3'h1;
  localparam logic [2:0] ADDR_TX_DATA = 3'h2;
  localparam logic [2:0] ADDR_RX_DATA = 3'h3;
  localparam logic [2:0] ADDR_DIVIDER = 3'h4;
  // serial_port_mode fields
  localparam int MODE_ENABLE_BIT = 15;
  localparam int MODE_IDLE_HALT_BIT = 13;
  localparam int MODE_INFRARED_BIT = 12;
  localparam int MODE_RTS_MODE_BIT = 11;
  localparam int MODE_PINS_LSB = 8;
  localparam int MODE_WAKE_BIT = 7;
  localparam int MODE_LOOP_BIT = 6;
  localparam int MODE_MEASURE_BIT = 5;
  localparam int MODE_RX_INVERT_BIT = 4;
  localparam int MODE_FAST_BIT = 3;
  localparam int MODE_FRAMING_LSB = 1;
  localparam int MODE_STOP_BIT = 0;
  localparam logic [15:0] MODE_WRITE_MASK = 16'hbbff;
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [15:0] DIVIDER_RESET = 16'h0000;
  // serial_port_status fields
  localparam int STATUS_TX_ENABLE_BIT = 10;
  localparam int STATUS_TX_FULL_BIT = 9;
  localparam int STATUS_TX_DONE_BIT = 8;
  localparam int STATUS_RX_IDLE_BIT = 4;
  localparam int STATUS_PARITY_ERR_BIT = 3;
  localparam int STATUS_FRAME_ERR_BIT = 2;
  localparam int STATUS_OVERRUN_BIT = 1;
  localparam int STATUS_RX_AVAIL_BIT = 0;
  // pin_usage_select codes
  localparam logic [1:0] PINS_TX_RX = 2'h0;
  localparam logic [1:0] PINS_RTS = 2'h1;
  localparam logic [1:0] PINS_RTS_CTS = 2'h2;
  localparam logic [1:0] PINS_OVERSAMPLE_CLK = 2'h3;
  // framing_select codes
  localparam logic [1:0] FRAME_8_NONE = 2'h0;
  localparam logic [1:0] FRAME_8_EVEN = 2'h1;
  localparam logic [1:0] FRAME_8_ODD = 2'h2;
  localparam logic [1:0] FRAME_9_NONE = 2'h3;
  // timing
  localparam logic [4:0] OVERSAMPLE_STD = 5'h10;
  localparam logic [4:0] OVERSAMPLE_FAST = 5'h04;
  localparam logic [4:0] IR_PULSE_TICKS = 5'h03;
  localparam logic [3:0] FRAME_BASE_BITS = 4'ha;
  // sync field 0x55 gives five falling edges over eight bit times
  localparam logic [2:0] SYNC_FALL_EDGES = 3'h5;
  localparam int MEASURE_SHIFT_STD = 8;
  localparam int MEASURE_SHIFT_FAST = 6;
  localparam int FIFO_DEPTH = 4;
endpackage

// *** hw/uart_mode_top.sv ***
`timescale 1ns/1ps
// Overview of operation
// - enable hands pins to port per fields
// - disable releases pins to general-purpose port
// - halt-in-idle stops port, but not auto-baud measurement, during processor idle
// - infrared bit inserts encoder and decoder
// - infrared codec only with 16x oversampling
// - rts mode: simplex or flow control
// - pin usage field selects owned pins
// - start bit in sleep raises wake
// - waking character is discarded
// - loopback routes transmitter into receiver
// - auto-baud measures 0x55 sync character
// - auto-baud bit self-clears when done
// - receive invert makes low line idle
// - fast select: 4 else 16 oversample ticks/bit
// - framing field selects data and parity
// - stop bit selects one or two stops
// - unused mode bits read zero
// - four-deep transmit and receive buffers
// - transmitter enable drives pin, clear aborts
module uart_mode_top #(
  parameter int FIFO_DEPTH = uart_cfg_pkg::FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [2:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic cpu_idle,
  input wire logic cpu_sleep,
  output logic wake_event,
  input wire logic serial_in_pin,
  input wire logic clear_to_send_in_n,
  output logic serial_out_pin,
  output logic serial_out_oe_n,
  output logic request_to_send_out_n,
  output logic request_to_send_oe_n,
  output logic oversample_clock_out,
  output logic oversample_clock_oe_n,
  output logic port_owns_rx,
  output logic port_owns_cts
);
  localparam int PW = $clog2(FIFO_DEPTH);

  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SHIFT = 2'b10} tx_state_e;
  typedef enum logic [2:0] {RX_IDLE = 3'b001, RX_SHIFT = 3'b010, RX_MEASURE = 3'b100} rx_state_e;

  logic [15:0] mode_reg, divider_reg, rdata_reg, div_cnt_reg;
  logic tx_en_reg, overrun_reg, perr_reg, ferr_reg, discard_reg, bclk_reg, wake_reg;
  logic serial_out_reg, rts_reg, rx_prev_reg;
  tx_state_e tx_state_reg;
  rx_state_e rx_state_reg;
  logic [11:0] tx_shift_reg, rx_frame_reg;
  logic [3:0] tx_bits_reg, rx_idx_reg;
  logic [4:0] tx_os_reg, rx_os_reg, ir_hold_reg;
  logic [22:0] measure_cnt_reg;
  logic [2:0] edges_reg;
  logic [1:0] f_push, f_pop, f_flush, f_full, f_empty;
  logic [17:0] f_din, f_dout;

  // mode fields
  wire enable = mode_reg[uart_cfg_pkg::MODE_ENABLE_BIT];
  wire idle_halt = mode_reg[uart_cfg_pkg::MODE_IDLE_HALT_BIT];
  wire fast = mode_reg[uart_cfg_pkg::MODE_FAST_BIT];
  wire [1:0] pins = mode_reg[uart_cfg_pkg::MODE_PINS_LSB +: 2];
  wire [1:0] framing = mode_reg[uart_cfg_pkg::MODE_FRAMING_LSB +: 2];
  wire two_stops = mode_reg[uart_cfg_pkg::MODE_STOP_BIT];
  wire measure_on = mode_reg[uart_cfg_pkg::MODE_MEASURE_BIT];
  wire ir_on = mode_reg[uart_cfg_pkg::MODE_INFRARED_BIT] & ~fast;
  wire run = enable & ~(idle_halt & cpu_idle);
  wire [4:0] os = fast ? uart_cfg_pkg::OVERSAMPLE_FAST : uart_cfg_pkg::OVERSAMPLE_STD;
  wire has_ninth = framing != uart_cfg_pkg::FRAME_8_NONE;
  wire [3:0] frame_len = uart_cfg_pkg::FRAME_BASE_BITS + {3'h0, has_ninth} + {3'h0, two_stops};
  wire odd = framing == uart_cfg_pkg::FRAME_8_ODD;

  // bus decode
  wire wr_mode = wr && addr == uart_cfg_pkg::ADDR_MODE;
  wire wr_status = wr && addr == uart_cfg_pkg::ADDR_STATUS;
  wire wr_div = wr && addr == uart_cfg_pkg::ADDR_DIVIDER;
  wire clear_overrun = wr_status && !wdata[uart_cfg_pkg::STATUS_OVERRUN_BIT];

  // baud generator: half-period ticks, oversample tick on every second
  wire half_tick = run && div_cnt_reg == 16'h0000;
  wire os_tick = half_tick && bclk_reg;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_reg <= 16'h0000;
      bclk_reg <= 1'b0;
    end else if (!run) begin
      div_cnt_reg <= divider_reg;
      bclk_reg <= 1'b0;
    end else if (half_tick) begin
      div_cnt_reg <= divider_reg;
      bclk_reg <= ~bclk_reg;
    end else begin
      div_cnt_reg <= div_cnt_reg - 16'h0001;
    end
  end

  // buffers: index 0 transmit, index 1 receive
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : fifo
      logic [8:0] mem [FIFO_DEPTH];
      logic [PW:0] wp_reg, rp_reg;
      wire [PW:0] level = wp_reg - rp_reg;
      assign f_full[g] = level == (PW + 1)'(FIFO_DEPTH);
      assign f_empty[g] = level == '0;
      assign f_dout[g * 9 +: 9] = mem[rp_reg[PW-1:0]];
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          wp_reg <= '0;
          rp_reg <= '0;
        end else if (f_flush[g]) begin
          wp_reg <= '0;
          rp_reg <= '0;
        end else begin
          if (f_push[g] && !f_full[g]) begin
            wp_reg <= wp_reg + 1'b1;
          end
          if (f_pop[g] && !f_empty[g]) begin
            rp_reg <= rp_reg + 1'b1;
          end
        end
      end
      always_ff @(posedge clock) begin
        if (f_push[g] && !f_full[g]) begin
          mem[wp_reg[PW-1:0]] <= f_din[g * 9 +: 9];
        end
      end
    end
  endgenerate

  // transmitter
  wire tx_abort = !enable || !tx_en_reg;
  wire cts_ok = pins != uart_cfg_pkg::PINS_RTS_CTS || !clear_to_send_in_n;
  wire tx_go = tx_state_reg == TX_IDLE && !f_empty[0] && os_tick && cts_ok;
  wire [8:0] tx_word = f_dout[8:0];
  wire tx_ninth = framing == uart_cfg_pkg::FRAME_9_NONE ? tx_word[8] :
                  has_ninth ? (^tx_word[7:0]) ^ odd : 1'b1;
  wire tx_bit = tx_state_reg == TX_SHIFT ? tx_shift_reg[0] : 1'b1;
  wire ir_pulse = !tx_bit && tx_os_reg >= os - uart_cfg_pkg::IR_PULSE_TICKS;
  wire tx_line = ir_on ? ir_pulse : tx_bit;

  assign f_push[0] = wr && addr == uart_cfg_pkg::ADDR_TX_DATA && !tx_abort;
  assign f_din[8:0] = wdata[8:0];
  assign f_pop[0] = tx_go;
  assign f_flush[0] = tx_abort;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_state_reg <= TX_IDLE;
      tx_shift_reg <= 12'hfff;
      tx_bits_reg <= 4'h0;
      tx_os_reg <= 5'h00;
    end else if (tx_abort) begin
      tx_state_reg <= TX_IDLE;
    end else begin
      case (tx_state_reg)
        TX_IDLE: begin
          if (tx_go) begin
            tx_shift_reg <= {2'b11, tx_ninth, tx_word[7:0], 1'b0};
            tx_bits_reg <= frame_len;
            tx_os_reg <= os - 5'h01;
            tx_state_reg <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          if (os_tick) begin
            if (tx_os_reg == 5'h00) begin
              tx_shift_reg <= {1'b1, tx_shift_reg[11:1]};
              tx_bits_reg <= tx_bits_reg - 4'h1;
              tx_os_reg <= os - 5'h01;
              if (tx_bits_reg == 4'h1) begin
                tx_state_reg <= TX_IDLE;
              end
            end else begin
              tx_os_reg <= tx_os_reg - 5'h01;
            end
          end
        end
        default: tx_state_reg <= TX_IDLE;
      endcase
    end
  end

  // receive line conditioning
  wire rx_pol = (mode_reg[uart_cfg_pkg::MODE_LOOP_BIT] ? tx_line : serial_in_pin)
                ^ mode_reg[uart_cfg_pkg::MODE_RX_INVERT_BIT];
  wire rx_line = ir_on ? !(rx_pol || ir_hold_reg != 5'h00) : rx_pol;
  wire rx_fall = rx_prev_reg && !rx_line;
  wire rx_start = rx_state_reg == RX_IDLE && rx_fall;
  wire rx_sample = rx_state_reg == RX_SHIFT && os_tick && rx_os_reg == 5'h00;
  wire rx_last = rx_sample && rx_idx_reg == frame_len - 4'h1;
  wire [11:0] rx_frame = rx_frame_reg | ({11'h000, rx_line} << rx_idx_reg);
  wire rx_perr = (framing == uart_cfg_pkg::FRAME_8_EVEN || odd) && ((^rx_frame[9:1]) != odd);
  wire wake_now = rx_start && cpu_sleep && mode_reg[uart_cfg_pkg::MODE_WAKE_BIT];
  wire [22:0] measured = fast ? measure_cnt_reg >> uart_cfg_pkg::MEASURE_SHIFT_FAST :
                         measure_cnt_reg >> uart_cfg_pkg::MEASURE_SHIFT_STD;
  wire measure_done = rx_state_reg == RX_MEASURE && rx_fall && edges_reg == uart_cfg_pkg::SYNC_FALL_EDGES - 3'h1;

  assign f_push[1] = rx_last && !discard_reg && !overrun_reg;
  assign f_din[17:9] = {framing == uart_cfg_pkg::FRAME_9_NONE && rx_frame[9], rx_frame[8:1]};
  assign f_pop[1] = rd && addr == uart_cfg_pkg::ADDR_RX_DATA;
  assign f_flush[1] = !enable || (clear_overrun && overrun_reg);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_prev_reg <= 1'b1;
      ir_hold_reg <= 5'h00;
    end else begin
      rx_prev_reg <= rx_line;
      if (rx_pol) begin
        ir_hold_reg <= os;
      end else if (os_tick && ir_hold_reg != 5'h00) begin
        ir_hold_reg <= ir_hold_reg - 5'h01;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_state_reg <= RX_IDLE;
      rx_frame_reg <= 12'h000;
      rx_idx_reg <= 4'h0;
      rx_os_reg <= 5'h00;
      measure_cnt_reg <= 23'h000000;
      edges_reg <= 3'h0;
      discard_reg <= 1'b0;
      wake_reg <= 1'b0;
    end else if (!enable) begin
      rx_state_reg <= RX_IDLE;
      discard_reg <= 1'b0;
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= wake_now;
      case (rx_state_reg)
        RX_IDLE: begin
          measure_cnt_reg <= 23'h000001;
          edges_reg <= 3'h1;
          rx_frame_reg <= 12'h000;
          rx_idx_reg <= 4'h0;
          rx_os_reg <= os >> 1;
          if (rx_fall && measure_on) begin
            rx_state_reg <= RX_MEASURE;
          end else if (rx_fall && run) begin
            rx_state_reg <= RX_SHIFT;
            discard_reg <= wake_now;
          end
        end
        RX_SHIFT: begin
          if (os_tick) begin
            rx_os_reg <= rx_sample ? os - 5'h01 : rx_os_reg - 5'h01;
          end
          if (rx_sample) begin
            rx_frame_reg <= rx_frame;
            rx_idx_reg <= rx_idx_reg + 4'h1;
            if (rx_idx_reg == 4'h0 && rx_line) begin
              rx_state_reg <= RX_IDLE;
            end
          end
          if (rx_last) begin
            rx_state_reg <= RX_IDLE;
            discard_reg <= 1'b0;
          end
        end
        RX_MEASURE: begin
          measure_cnt_reg <= measure_cnt_reg + 23'h000001;
          if (rx_fall) begin
            edges_reg <= edges_reg + 3'h1;
          end
          if (measure_done || !measure_on) begin
            rx_state_reg <= RX_IDLE;
          end
        end
        default: rx_state_reg <= RX_IDLE;
      endcase
    end
  end

  // registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= uart_cfg_pkg::MODE_RESET;
      divider_reg <= uart_cfg_pkg::DIVIDER_RESET;
      tx_en_reg <= 1'b0;
    end else begin
      if (wr_mode) begin
        mode_reg <= wdata & uart_cfg_pkg::MODE_WRITE_MASK;
      end else if (measure_done) begin
        mode_reg[uart_cfg_pkg::MODE_MEASURE_BIT] <= 1'b0;
      end
      if (wr_div) begin
        divider_reg <= wdata;
      end else if (measure_done) begin
        divider_reg <= measured[15:0] - 16'h0001;
      end
      if (wr_status) begin
        tx_en_reg <= wdata[uart_cfg_pkg::STATUS_TX_ENABLE_BIT];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      overrun_reg <= 1'b0;
      perr_reg <= 1'b0;
      ferr_reg <= 1'b0;
    end else begin
      if (rx_last && !discard_reg && (f_full[1] || overrun_reg)) begin
        overrun_reg <= 1'b1;
      end else if (clear_overrun) begin
        overrun_reg <= 1'b0;
      end
      if (f_push[1]) begin
        perr_reg <= rx_perr;
        ferr_reg <= !rx_line;
      end
    end
  end

  // status word and read mux
  logic [15:0] status_word;
  always_comb begin
    status_word = 16'h0000;
    status_word[uart_cfg_pkg::STATUS_TX_ENABLE_BIT] = tx_en_reg;
    status_word[uart_cfg_pkg::STATUS_TX_FULL_BIT] = f_full[0];
    status_word[uart_cfg_pkg::STATUS_TX_DONE_BIT] = f_empty[0] && tx_state_reg == TX_IDLE;
    status_word[uart_cfg_pkg::STATUS_RX_IDLE_BIT] = rx_state_reg == RX_IDLE;
    status_word[uart_cfg_pkg::STATUS_PARITY_ERR_BIT] = perr_reg;
    status_word[uart_cfg_pkg::STATUS_FRAME_ERR_BIT] = ferr_reg;
    status_word[uart_cfg_pkg::STATUS_OVERRUN_BIT] = overrun_reg;
    status_word[uart_cfg_pkg::STATUS_RX_AVAIL_BIT] = !f_empty[1];
  end

  wire [15:0] read_word = addr == uart_cfg_pkg::ADDR_MODE ? mode_reg :
                          addr == uart_cfg_pkg::ADDR_STATUS ? status_word :
                          addr == uart_cfg_pkg::ADDR_RX_DATA ? {7'h00, f_dout[17:9]} :
                          addr == uart_cfg_pkg::ADDR_DIVIDER ? divider_reg : 16'h0000;

  // rts: simplex asserts while sending, flow control while room remains
  wire rts_next_n = mode_reg[uart_cfg_pkg::MODE_RTS_MODE_BIT] ?
                    (f_empty[0] && tx_state_reg == TX_IDLE) : f_full[1];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 16'h0000;
      serial_out_reg <= 1'b1;
      rts_reg <= 1'b1;
    end else begin
      if (rd) begin
        rdata_reg <= read_word;
      end
      serial_out_reg <= tx_line;
      rts_reg <= rts_next_n;
    end
  end

  assign rdata = rdata_reg;
  assign wake_event = wake_reg;
  assign serial_out_pin = serial_out_reg;
  assign request_to_send_out_n = rts_reg;
  assign oversample_clock_out = bclk_reg;
  assign serial_out_oe_n = !(enable && tx_en_reg);
  assign request_to_send_oe_n = !(enable && (pins == uart_cfg_pkg::PINS_RTS ||
                                             pins == uart_cfg_pkg::PINS_RTS_CTS));
  assign oversample_clock_oe_n = !(enable && pins == uart_cfg_pkg::PINS_OVERSAMPLE_CLK);
  assign port_owns_rx = enable;
  assign port_owns_cts = enable && pins == uart_cfg_pkg::PINS_RTS_CTS;
endmodule // uart_mode_top

// *** tb/test_uart_mode_configuration.sv ***
`timescale 1ns/1ps
module test_uart_mode_configuration;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic cpu_idle = 1'b0;
  logic cpu_sleep = 1'b0;
  logic woke = 1'b0;
  logic cts_n = 1'b0;
  int n_mismatch = 0;
  int n_checks = 0;
  wire [15:0] rdata;
  wire wake_event, rx_line, tx_line, tx_oe_n, rts_n, rts_oe_n, bclk, bclk_oe_n, owns_rx, owns_cts;
  always #12.5 clock = ~clock;
  uart_mode_top #(.FIFO_DEPTH(4)) DUT (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep), .wake_event(wake_event),
    .serial_in_pin(rx_line), .clear_to_send_in_n(cts_n), .serial_out_pin(tx_line), .serial_out_oe_n(tx_oe_n),
    .request_to_send_out_n(rts_n), .request_to_send_oe_n(rts_oe_n), .oversample_clock_out(bclk),
    .oversample_clock_oe_n(bclk_oe_n), .port_owns_rx(owns_rx), .port_owns_cts(owns_cts));
  uart_far_end far (.clock(clock), .tx_line(tx_line), .rx_line(rx_line));
  always @(posedge clock) if (wake_event === 1'b1) woke <= 1'b1;
  task automatic bus_write(input logic [2:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    #1;
  endtask
  task automatic bus_read(input logic [2:0] a, output logic [15:0] v);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic chk_reg(input string n, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_pin(input string n, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic wrap_up();
    if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  function automatic logic [15:0] exp_frame(input logic [8:0] d, input logic [1:0] c);
    logic ninth;
    ninth = (c == 2'h3) ? d[8] : (c == 2'h1) ? ^d[7:0] : ~^d[7:0];
    return (c == 2'h0) ? {4'hf, 3'h7, d[7:0], 1'b0} : {4'hf, 2'h3, ninth, d[7:0], 1'b0};
  endfunction
  initial begin
    repeat (100000) @(posedge clock);
    n_mismatch++;
    wrap_up();
  end
  initial begin
    logic [15:0] v;
    logic [11:0] f;
    int lows;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    bus_read(uart_cfg_pkg::ADDR_MODE, v);
    chk_reg("mode reset", 16'h0000, v);
    bus_read(3'h5, v);
    chk_reg("unmapped", 16'h0000, v);
    bus_write(uart_cfg_pkg::ADDR_MODE, 16'h7bdf);
    bus_read(uart_cfg_pkg::ADDR_MODE, v);
    chk_reg("mode rw", 16'h3bdf, v);
    chk_pin("tx oe off", 1'b1, tx_oe_n);
    chk_pin("rx own off", 1'b0, owns_rx);
    for (int u = 0; u < 4; u++) begin
      bus_write(uart_cfg_pkg::ADDR_MODE, 16'h8000 | (16'(u) << 8));
      chk_pin("rts oe", !(u == 1 || u == 2), rts_oe_n);
      chk_pin("bclk oe", u != 3, bclk_oe_n);
      chk_pin("cts own", u == 2, owns_cts);
      chk_pin("rx own", 1'b1, owns_rx);
    end
    f[0] = bclk;
    @(posedge clock);
    #1;
    chk_pin("bclk toggles", !f[0], bclk);
    bus_write(uart_cfg_pkg::ADDR_MODE, 16'h8000);
    bus_write(uart_cfg_pkg::ADDR_STATUS, 16'h0400);
    chk_pin("tx oe on", 1'b0, tx_oe_n);
    for (int c = 0; c < 4; c++) begin
      bus_write(uart_cfg_pkg::ADDR_MODE, 16'h8000 | 16'(c << 1));
      fork
        far.capture(f, 32);
        bus_write(uart_cfg_pkg::ADDR_TX_DATA, 16'h01a6);
      join
      chk_reg("frame", exp_frame(9'h1a6, 2'(c)), {4'hf, f});
    end
    bus_write(uart_cfg_pkg::ADDR_MODE, 16'h8008);
    fork
      far.capture(f, 8);
      bus_write(uart_cfg_pkg::ADDR_TX_DATA, 16'h005a);
    join
    chk_reg("fast frame", exp_frame(9'h05a, 2'h0), {4'hf, f});
    bus_write(uart_cfg_pkg::ADDR_MODE, 16'h8a00);
    @(posedge clock) cts_n <= 1'b1;
    bus_write(uart_cfg_pkg::ADDR_TX_DATA, 16'h0011);
    // rts is registered: settles one edge after the push
    @(posedge clock);
    #1;
    chk_pin("simplex rts busy", 1'b0, rts_n);
    repeat (140) @(posedge clock);
    chk_pin("cts holds tx", 1'b1, tx_line);
    cts_n <= 1'b0;
    repeat (400) @(posedge clock);
    chk_pin("simplex rts idle", 1'b1, rts_n);
    bus_write(uart_cfg_pkg::ADDR_MODE, 16'h8040);
    bus_write(uart_cfg_pkg::ADDR_TX_DATA, 16'h003c);
    repeat (400) @(posedge clock);
    bus_read(uart_cfg_pkg::ADDR_RX_DATA, v);
    chk_reg("loop data", 16'h003c, v);
    bus_write(uart_cfg_pkg::ADDR_MODE, 16'h8010);
    far.inv_reg = 1'b1;
    far.send(9'h0a5, 8, 1, 32);
    repeat (40) @(posedge clock);
    bus_read(uart_cfg_pkg::ADDR_RX_DATA, v);
    chk_reg("inverted rx", 16'h00a5, v);
    bus_write(uart_cfg_pkg::ADDR_MODE, 16'h0000);
    far.inv_reg = 1'b0;
    bus_write(uart_cfg_pkg::ADDR_MODE, 16'h8020);
    far.send(9'h055, 8, 1, 64);
    repeat (20) @(posedge clock);
    bus_read(uart_cfg_pkg::ADDR_MODE, v);
    chk_reg("measure done", 16'h8000, v);
    bus_read(uart_cfg_pkg::ADDR_DIVIDER, v);
    chk_reg("measured divider", 16'h0001, v);
    bus_write(uart_cfg_pkg::ADDR_MODE, 16'h0000);
    bus_write(uart_cfg_pkg::ADDR_MODE, 16'h8080);
    @(posedge clock) cpu_sleep <= 1'b1;
    far.send(9'h033, 8, 2, 64);
    repeat (200) @(posedge clock);
    chk_pin("wake seen", 1'b1, woke);
    cpu_sleep <= 1'b0;
    bus_read(uart_cfg_pkg::ADDR_STATUS, v);
    chk_pin("wake char dropped", 1'b0, v[0]);
    bus_write(uart_cfg_pkg::ADDR_MODE, 16'h9000);
    repeat (4) @(posedge clock);
    chk_pin("infrared idle", 1'b0, tx_line);
    bus_write(uart_cfg_pkg::ADDR_MODE, 16'h9008);
    repeat (4) @(posedge clock);
    chk_pin("infrared off fast", 1'b1, tx_line);
    bus_write(uart_cfg_pkg::ADDR_MODE, 16'ha000);
    @(posedge clock) cpu_idle <= 1'b1;
    for (int i = 0; i < 3; i++) bus_write(uart_cfg_pkg::ADDR_TX_DATA, 16'h0000);
    bus_read(uart_cfg_pkg::ADDR_STATUS, v);
    chk_pin("tx three not full", 1'b0, v[9]);
    for (int i = 0; i < 2; i++) bus_write(uart_cfg_pkg::ADDR_TX_DATA, 16'h0000);
    lows = 0;
    for (int i = 0; i < 400; i++) begin
      @(posedge clock);
      lows += (tx_line !== 1'b1);
    end
    chk_reg("halted line lows", 16'h0000, 16'(lows));
    chk_pin("halted bclk", 1'b0, bclk);
    bus_read(uart_cfg_pkg::ADDR_STATUS, v);
    chk_pin("tx full", 1'b1, v[9]);
    bus_write(uart_cfg_pkg::ADDR_STATUS, 16'h0000);
    bus_read(uart_cfg_pkg::ADDR_STATUS, v);
    chk_pin("tx flushed", 1'b0, v[9]);
    chk_pin("tx oe off again", 1'b1, tx_oe_n);
    cpu_idle <= 1'b0;
    wrap_up();
  end
endmodule // test_uart_mode_configuration

// *** tb/uart_far_end.sv ***
`timescale 1ns/1ps
module uart_far_end (
  input wire logic clock,
  input wire logic tx_line,
  output logic rx_line
);
  logic line_reg = 1'b1;
  logic inv_reg = 1'b0;
  assign rx_line = line_reg ^ inv_reg;
  task automatic send(input logic [8:0] d, input int nbits, input int stops, input int bitclk);
    logic [11:0] f;
    f = 12'hfff;
    f[0] = 1'b0;
    for (int i = 0; i < nbits; i++) f[i + 1] = d[i];
    for (int i = 0; i < 1 + nbits + stops; i++) begin
      @(posedge clock);
      line_reg <= f[i];
      repeat (bitclk - 1) @(posedge clock);
    end
  endtask
  // samples twelve bit times from the first start edge, mid-bit
  task automatic capture(output logic [11:0] v, input int bitclk);
    int n;
    v = 'x;
    n = 0;
    while (tx_line !== 1'b0 && n < 4000) begin
      @(posedge clock);
      n++;
    end
    if (n < 4000) begin
      repeat (bitclk / 2) @(posedge clock);
      for (int i = 0; i < 12; i++) begin
        v[i] = tx_line;
        repeat (bitclk) @(posedge clock);
      end
    end
  endtask
endmodule // uart_far_end

// *** tb/uart_mode_chk.sv ***
`timescale 1ns/1ps
module uart_mode_chk (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [2:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  input wire logic cpu_sleep,
  input wire logic wake_event,
  input wire logic serial_out_oe_n,
  input wire logic request_to_send_oe_n,
  input wire logic oversample_clock_oe_n,
  input wire logic port_owns_rx,
  input wire logic port_owns_cts
);
  logic [15:0] mode_reg;
  logic txen_reg;
  wire en = mode_reg[15];
  wire [1:0] pins = mode_reg[9:8];
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= 16'h0000;
      txen_reg <= 1'b0;
    end else if (wr) begin
      if (addr == uart_cfg_pkg::ADDR_MODE) mode_reg <= wdata & 16'hbbff;
      if (addr == uart_cfg_pkg::ADDR_STATUS) txen_reg <= wdata[10];
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_pins_released: assert property (!en |-> serial_out_oe_n && request_to_send_oe_n && oversample_clock_oe_n
    && !port_owns_rx && !port_owns_cts) else $error("pins not released while disabled");
  a_tx_drive: assert property (en && txen_reg |-> !serial_out_oe_n)
    else $error("transmit pin not driven");
  a_rts_owned: assert property (en |-> request_to_send_oe_n == !(pins == 2'h1 || pins == 2'h2))
    else $error("rts ownership wrong");
  a_bclk_owned: assert property (en |-> oversample_clock_oe_n == (pins != 2'h3))
    else $error("baud clock ownership wrong");
  a_owns_follow: assert property (port_owns_rx == en && port_owns_cts == (en && pins == 2'h2))
    else $error("rx or cts ownership wrong");
  a_mode_readback: assert property (rd && addr == uart_cfg_pkg::ADDR_MODE |=>
    (rdata & 16'hbbdf) == ($past(mode_reg) & 16'hbbdf)) else $error("mode readback wrong");
  a_unused_zero: assert property (rd && addr == uart_cfg_pkg::ADDR_MODE |=> !rdata[14] && !rdata[10])
    else $error("unused mode bits not zero");
  a_unmapped_zero: assert property (rd && addr > 3'h4 |=> rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_wake_gate: assert property (wake_event |-> $past(cpu_sleep) && $past(mode_reg[7]))
    else $error("wake without sleep and wake bit");
  a_wake_pulse: assert property (wake_event |=> !wake_event)
    else $error("wake longer than one cycle");
  c_mode_read: cover property (rd && addr == uart_cfg_pkg::ADDR_MODE);
  c_wake: cover property (wake_event);
  c_tx_on: cover property (en && txen_reg);
endmodule // uart_mode_chk
bind uart_mode_top uart_mode_chk u_chk (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .cpu_sleep(cpu_sleep), .wake_event(wake_event), .serial_out_oe_n(serial_out_oe_n),
  .request_to_send_oe_n(request_to_send_oe_n), .oversample_clock_oe_n(oversample_clock_oe_n),
  .port_owns_rx(port_owns_rx), .port_owns_cts(port_owns_cts));
